// [inc/cbf_pkg.sv]
// Constants, cycle-type codes and shared decode for the cable transfer bus.
// Assumes both ends run on one clock and see the resolved bus lines.
package cbf_pkg;
    localparam int AD_W = 32;
    localparam int CL_W = 4;
    localparam int ID_W = 5;
    // Address-phase control line codes
    localparam logic [3:0] CT_DIR_C = 4'h8;
    localparam logic [3:0] CT_NC1 = 4'h9;
    localparam logic [3:0] CT_NC2 = 4'ha;
    localparam logic [3:0] CT_LANE = 4'h4;
    localparam logic [3:0] CT_IACK = 4'h7;
    localparam logic [1:0] CT_A64_HI = 2'h0;
    localparam logic [1:0] CT_VME_HI = 2'h3;
    // Data-phase control line fields
    localparam int CLB_BLT = 3;
    localparam int CLB_WR = 2;
    localparam logic [4:0] DEV_BCAST = 5'h00;
    localparam logic [4:0] RS_STAT = 5'h00;
    localparam logic [4:0] RS_BANK = 5'h1f;
    localparam int NREG = 32;
    localparam int BANK_D = 16;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam int CLK_NS = 40;
    localparam int ACK_TMO_NS = 2000;
    localparam int ACK_TMO_CYC = ACK_TMO_NS / CLK_NS;
    localparam logic [1:0] BPK_VME = 2'h0;
    localparam logic [1:0] BPK_A64 = 2'h1;
    localparam logic [1:0] BPK_LANE = 2'h2;

    typedef enum logic [2:0] {
        K_RSVD, K_DIRC, K_NC1, K_NC2, K_A64, K_VME, K_LANE, K_IACK
    } cbf_kind_t;

    function automatic cbf_kind_t cbf_classify(input logic [3:0] c);
        cbf_kind_t k;
        k = K_RSVD;
        if (c[3:2] == CT_A64_HI) k = K_A64;
        else if (c[3:2] == CT_VME_HI) k = K_VME;
        else if (c == CT_LANE) k = K_LANE;
        else if (c == CT_IACK) k = K_IACK;
        else if (c == CT_DIR_C) k = K_DIRC;
        else if (c == CT_NC1) k = K_NC1;
        else if (c == CT_NC2) k = K_NC2;
        return k;
    endfunction

    // Lane mask, bit 3 is the most significant byte lane
    function automatic logic [3:0] cbf_lanes(input logic [1:0] off,
                                             input logic [1:0] dsel);
        logic [3:0] top;
        case (dsel)
            2'h1: top = 4'h8;
            2'h2: top = 4'hc;
            2'h3: top = 4'he;
            default: top = 4'hf;
        endcase
        return top >> off;
    endfunction
endpackage

// [inc/cbf_bus_if.sv]
// Transfer bus between one master end and one slave end.
// Resolves the wired-OR lines from each party's drive and enable.
`timescale 1ns/1ps
interface cbf_bus_if;
    logic [31:0] m_ad;
    logic m_ad_oe;
    logic [3:0] m_cl;
    logic [4:0] m_id;
    logic m_info_oe;
    logic m_as;
    logic m_ds;
    logic m_tim_oe;
    logic [31:0] s_ad;
    logic s_ad_oe;
    logic s_wt;
    logic s_syserr;
    logic [31:0] ad;
    logic [3:0] cl;
    logic [4:0] id;
    logic as_l;
    logic ds_l;
    logic wt;
    logic syserr;

    assign ad = (m_ad & {32{m_ad_oe}}) | (s_ad & {32{s_ad_oe}});
    assign cl = m_cl & {4{m_info_oe}};
    assign id = m_id & {5{m_info_oe}};
    assign as_l = m_as & m_tim_oe;
    assign ds_l = m_ds & m_tim_oe;
    assign wt = s_wt;
    assign syserr = s_syserr;

    modport master (output m_ad, m_ad_oe, m_cl, m_id, m_info_oe, m_as, m_ds,
                    m_tim_oe, input ad, wt, syserr);
    modport slave (output s_ad, s_ad_oe, s_wt, s_syserr,
                   input ad, cl, id, as_l, ds_l, wt);
endinterface

// [hdl/cbf_master.sv]
// Master end of the transfer bus: runs one bus cycle per user request.
// Assumes the arbiter outside gives bus_grant and that the slave shares
// sys_clk, so bus lines are read without synchronisers.
`timescale 1ns/1ps
module cbf_master (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    cbf_bus_if.master bus,
    input wire logic bus_grant,
    input wire logic req,
    input wire logic [3:0] req_type,
    input wire logic [4:0] req_dev,
    input wire logic [31:0] req_addr,
    input wire logic [5:0] req_ae,
    input wire logic [4:0] req_rs,
    input wire logic req_write,
    input wire logic [1:0] req_dsel,
    input wire logic [4:0] req_beats,
    input wire logic [31:0] wdata,
    output logic busy,
    output logic wd_take,
    output logic rd_valid,
    output logic [31:0] rd_data,
    output logic done,
    output logic err
);
    typedef enum {M_IDLE, M_ADR, M_BEAT, M_PULSE, M_HS, M_REL, M_DRAIN,
                  M_END} cbf_mst_t;
    cbf_mst_t st_r;
    cbf_pkg::cbf_kind_t kind_r;
    cbf_pkg::cbf_kind_t k;
    logic [31:0] ad_r;
    logic [3:0] cl_r;
    logic [4:0] id_r;
    logic ad_oe_r, info_oe_r, as_r, ds_r;
    logic wr_r, blt_r, pipe_r;
    logic [1:0] dsel_r;
    logic [4:0] rs_r, left_r, pend_r;
    logic [3:0] ae_lo_r;
    logic [5:0] tmo_r;
    logic busy_r, take_r, rdv_r, done_r, err_r;
    logic [31:0] rdd_r;
    logic bad, go, tmo_hit, resp, waiting;

    always_comb begin
        k = cbf_pkg::cbf_classify(req_type);
        // Reserved and acknowledge codes are not run; no broadcall read on the
        // second uncompelled type, and the first uncompelled type only writes
        bad = (k == cbf_pkg::K_RSVD) || (k == cbf_pkg::K_IACK)
            || (k == cbf_pkg::K_NC1 && !req_write)
            || (k == cbf_pkg::K_NC2 && !req_write
                && req_dev == cbf_pkg::DEV_BCAST);
        go = req && st_r == M_IDLE && bus_grant && !bad;
        resp = bus.wt;
        tmo_hit = tmo_r == 6'(cbf_pkg::ACK_TMO_CYC);
        waiting = st_r == M_HS || st_r == M_REL || st_r == M_DRAIN;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= M_IDLE;
            kind_r <= cbf_pkg::K_RSVD;
            ad_r <= 32'h0;
            cl_r <= 4'h0;
            id_r <= 5'h0;
            {ad_oe_r, info_oe_r, as_r, ds_r} <= 4'h0;
            {wr_r, blt_r, pipe_r} <= 3'h0;
            dsel_r <= 2'h0;
            rs_r <= 5'h0;
            left_r <= 5'h0;
            ae_lo_r <= 4'h0;
            {busy_r, take_r, rdv_r, done_r, err_r} <= 5'h0;
            rdd_r <= 32'h0;
        end else if (ce) begin
            {take_r, rdv_r, done_r, err_r} <= 4'h0;
            if (pipe_r && resp && !wr_r) begin
                rdd_r <= bus.ad;
                rdv_r <= 1'b1;
            end
            case (st_r)
                M_IDLE: begin
                    if (req && !go) begin
                        err_r <= 1'b1;
                    end else if (go) begin
                        ad_r <= req_addr;
                        cl_r <= req_type;
                        if (k == cbf_pkg::K_A64 || k == cbf_pkg::K_VME) begin
                            cl_r <= {req_type[3:2], req_ae[5:4]};
                        end
                        id_r <= req_dev;
                        {ad_oe_r, info_oe_r, as_r} <= 3'h7;
                        kind_r <= k;
                        wr_r <= req_write;
                        dsel_r <= req_dsel;
                        rs_r <= req_rs;
                        ae_lo_r <= req_ae[3:0];
                        left_r <= (req_beats == 5'h0) ? 5'h0 : req_beats - 5'h1;
                        blt_r <= req_beats > 5'h1;
                        pipe_r <= 1'b0;
                        busy_r <= 1'b1;
                        st_r <= M_ADR;
                    end
                end
                M_ADR: begin
                    cl_r <= {blt_r, wr_r, dsel_r};
                    id_r <= (kind_r == cbf_pkg::K_DIRC || kind_r == cbf_pkg::K_NC1
                             || kind_r == cbf_pkg::K_NC2) ? rs_r
                                                          : {1'b0, ae_lo_r};
                    ad_oe_r <= wr_r;
                    st_r <= M_BEAT;
                end
                M_BEAT: begin
                    ds_r <= 1'b1;
                    if (wr_r) begin
                        ad_r <= wdata;
                        take_r <= 1'b1;
                    end
                    st_r <= (pipe_r || kind_r == cbf_pkg::K_NC1) ? M_PULSE
                                                                : M_HS;
                end
                M_PULSE: begin
                    ds_r <= 1'b0;
                    if (left_r != 5'h0) begin
                        left_r <= left_r - 5'h1;
                        st_r <= M_BEAT;
                    end else begin
                        st_r <= (kind_r == cbf_pkg::K_NC2) ? M_DRAIN : M_END;
                    end
                end
                M_HS: begin
                    if (resp) begin
                        ds_r <= 1'b0;
                        if (!wr_r) begin
                            rdd_r <= bus.ad;
                            rdv_r <= 1'b1;
                        end
                        st_r <= M_REL;
                    end else if (tmo_hit) begin
                        err_r <= 1'b1;
                        st_r <= M_END;
                    end
                end
                M_REL: begin
                    if (!resp) begin
                        pipe_r <= kind_r == cbf_pkg::K_NC2;
                        if (left_r != 5'h0) begin
                            left_r <= left_r - 5'h1;
                            st_r <= M_BEAT;
                        end else begin
                            st_r <= M_END;
                        end
                    end else if (tmo_hit) begin
                        err_r <= 1'b1;
                        st_r <= M_END;
                    end
                end
                M_DRAIN: begin
                    if (pend_r == 5'h0) begin
                        st_r <= M_END;
                    end else if (tmo_hit) begin
                        err_r <= 1'b1;
                        st_r <= M_END;
                    end
                end
                M_END: begin
                    {ad_oe_r, info_oe_r, as_r, ds_r} <= 4'h0;
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    st_r <= M_IDLE;
                end
                default: st_r <= M_IDLE;
            endcase
        end
    end

    // Pipelined answers still owed; a dead slave is caught by the timeout
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_r <= 5'h0;
        end else if (ce) begin
            if (st_r == M_IDLE) pend_r <= 5'h0;
            else pend_r <= pend_r + {4'h0, st_r == M_BEAT && pipe_r}
                           - {4'h0, pipe_r && resp};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) tmo_r <= 6'h0;
        else if (ce) begin
            if (!waiting || (pipe_r && resp)) tmo_r <= 6'h0;
            else if (!tmo_hit) tmo_r <= tmo_r + 6'h1;
        end
    end

    assign bus.m_ad = ad_r;
    assign bus.m_ad_oe = ad_oe_r;
    assign bus.m_cl = cl_r;
    assign bus.m_id = id_r;
    assign bus.m_info_oe = info_oe_r;
    assign bus.m_as = as_r;
    assign bus.m_ds = ds_r;
    assign bus.m_tim_oe = info_oe_r;
    assign busy = busy_r;
    assign wd_take = take_r;
    assign rd_valid = rdv_r;
    assign rd_data = rdd_r;
    assign done = done_r;
    assign err = err_r;
endmodule

// [hdl/cbf_slave.sv]
// Slave end of the transfer bus: register locations, backplane bridge
// requests and a passive spy port. Assumes the master shares sys_clk.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module cbf_slave (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    cbf_bus_if.slave bus,
    input wire logic [4:0] own_dev,
    input wire logic bcast_en,
    input wire logic [31:0] stat_in,
    input wire logic bp_done,
    input wire logic bp_err,
    input wire logic [31:0] bp_rdata,
    output logic bp_req,
    output logic bp_write,
    output logic [1:0] bp_kind,
    output logic [31:0] bp_addr,
    output logic [5:0] bp_am,
    output logic [3:0] bp_lanes,
    output logic [31:0] bp_wdata,
    output logic reg_wr,
    output logic [4:0] reg_wr_idx,
    output logic selected,
    output logic spy_valid,
    output logic [31:0] spy_data
);
    typedef enum {S_IDLE, S_DATA, S_BP, S_ACK} cbf_slv_t;
    cbf_slv_t st_r;
    cbf_pkg::cbf_kind_t kind_r;
    cbf_pkg::cbf_kind_t k;
    logic [31:0] regs_r [cbf_pkg::NREG];
    logic [31:0] bank_r [cbf_pkg::BANK_D];
    logic as_q, ds_q, wt_q;
    logic [29:0] word_r;
    logic [1:0] off_r, aehi_r;
    logic bc_r, first_r, sel_r;
    logic [31:0] ad_r;
    logic ad_oe_r, wt_r, syserr_r;
    logic bp_req_r, bp_wr_r, rw_r, spv_r;
    logic [1:0] bpk_r;
    logic [31:0] bpa_r, bpw_r, spd_r;
    logic [5:0] bpam_r;
    logic [3:0] bpl_r;
    logic [4:0] rwi_r;
    logic as_rise, ds_rise, hit, take, trans, bwr, skip, beat, dwr;
    logic [4:0] rs;
    logic [3:0] lanes;
    logic [31:0] rdv;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] ln);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (ln[b]) r[8*b +: 8] = nw[8*b +: 8];
        end
        return r;
    endfunction

    always_comb begin
        as_rise = bus.as_l && !as_q;
        ds_rise = bus.ds_l && !ds_q;
        k = cbf_pkg::cbf_classify(bus.cl);
        hit = (bus.id == own_dev)
            || (bus.id == cbf_pkg::DEV_BCAST && bcast_en);
        take = hit && k != cbf_pkg::K_RSVD && k != cbf_pkg::K_IACK;
        trans = kind_r == cbf_pkg::K_A64 || kind_r == cbf_pkg::K_VME
             || kind_r == cbf_pkg::K_LANE;
        bwr = bus.cl[cbf_pkg::CLB_WR];
        rs = bus.id;
        lanes = cbf_pkg::cbf_lanes(off_r, bus.cl[1:0]);
        // Uncompelled reads are write-only for type 1 and never broadcall
        skip = !bwr && (kind_r == cbf_pkg::K_NC1
                        || (kind_r == cbf_pkg::K_NC2 && bc_r));
        beat = st_r == S_DATA && bus.as_l && ds_rise && !skip;
        dwr = beat && !trans && bwr;
        if (rs == cbf_pkg::RS_STAT) rdv = stat_in;
        else if (rs == cbf_pkg::RS_BANK) rdv = bank_r[word_r[3:0]];
        else rdv = regs_r[rs];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) {as_q, ds_q, wt_q} <= 3'h0;
        else if (ce) {as_q, ds_q, wt_q} <= {bus.as_l, bus.ds_l, bus.wt};
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= S_IDLE;
            kind_r <= cbf_pkg::K_RSVD;
            word_r <= 30'h0;
            {off_r, aehi_r} <= 4'h0;
            {bc_r, first_r, sel_r} <= 3'h0;
            ad_r <= 32'h0;
            {ad_oe_r, wt_r, syserr_r} <= 3'h0;
            {bp_req_r, bp_wr_r} <= 2'h0;
            bpk_r <= 2'h0;
            {bpa_r, bpw_r} <= 64'h0;
            bpam_r <= 6'h0;
            bpl_r <= 4'h0;
        end else if (ce) begin
            bp_req_r <= 1'b0;
            if (st_r != S_IDLE && !bus.as_l) begin
                {ad_oe_r, wt_r, syserr_r, sel_r} <= 4'h0;
                st_r <= S_IDLE;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (as_rise && take) begin
                            kind_r <= k;
                            word_r <= bus.ad[31:2];
                            off_r <= bus.ad[1:0];
                            aehi_r <= bus.cl[1:0];
                            bc_r <= bus.id == cbf_pkg::DEV_BCAST;
                            first_r <= 1'b1;
                            sel_r <= 1'b1;
                            st_r <= S_DATA;
                        end
                    end
                    S_DATA: begin
                        // Pipelined answers last one cycle only
                        wt_r <= 1'b0;
                        ad_oe_r <= 1'b0;
                        if (beat) begin
                            first_r <= 1'b0;
                            if (bus.cl[cbf_pkg::CLB_BLT]) begin
                                word_r <= word_r + 30'h1;
                            end
                            if (trans) begin
                                bp_req_r <= 1'b1;
                                bp_wr_r <= bwr;
                                bpa_r <= {word_r, off_r};
                                bpam_r <= {aehi_r, bus.id[3:0]};
                                bpk_r <= (kind_r == cbf_pkg::K_A64) ?
                                         cbf_pkg::BPK_A64 :
                                         (kind_r == cbf_pkg::K_LANE) ?
                                         cbf_pkg::BPK_LANE :
                                         cbf_pkg::BPK_VME;
                                bpw_r <= bus.ad;
                                bpl_r <= lanes;
                                st_r <= S_BP;
                            end else begin
                                ad_r <= rdv;
                                ad_oe_r <= !bwr && kind_r != cbf_pkg::K_NC1;
                                if (kind_r == cbf_pkg::K_DIRC
                                    || (kind_r == cbf_pkg::K_NC2 && first_r)) begin
                                    wt_r <= 1'b1;
                                    st_r <= S_ACK;
                                end else if (kind_r == cbf_pkg::K_NC2) begin
                                    wt_r <= 1'b1;
                                end
                            end
                        end
                    end
                    S_BP: begin
                        if (bp_done) begin
                            ad_r <= bp_rdata;
                            ad_oe_r <= !bp_wr_r;
                            syserr_r <= bp_err;
                            wt_r <= 1'b1;
                            st_r <= S_ACK;
                        end
                    end
                    S_ACK: begin
                        if (!bus.ds_l) begin
                            {ad_oe_r, wt_r, syserr_r} <= 3'h0;
                            st_r <= S_DATA;
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // Location 0 reads live status and ignores writes
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < cbf_pkg::NREG; i++) regs_r[i] <= cbf_pkg::REG_RST;
            for (int i = 0; i < cbf_pkg::BANK_D; i++) bank_r[i] <= cbf_pkg::REG_RST;
            rw_r <= 1'b0;
            rwi_r <= 5'h0;
        end else if (ce) begin
            rw_r <= dwr;
            if (dwr) begin
                rwi_r <= rs;
                if (rs == cbf_pkg::RS_BANK) begin
                    bank_r[word_r[3:0]] <= merge(bank_r[word_r[3:0]], bus.ad,
                                                 lanes);
                end else if (rs != cbf_pkg::RS_STAT) begin
                    regs_r[rs] <= merge(regs_r[rs], bus.ad, lanes);
                end
            end
        end
    end

    // Spy sees every data value whether selected or not
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            spv_r <= 1'b0;
            spd_r <= 32'h0;
        end else if (ce) begin
            spv_r <= 1'b0;
            if (bus.as_l && ((ds_rise && bwr)
                             || (bus.wt && !wt_q && !bwr))) begin
                spv_r <= 1'b1;
                spd_r <= bus.ad;
            end
        end
    end

    assign bus.s_ad = ad_r;
    assign bus.s_ad_oe = ad_oe_r;
    assign bus.s_wt = wt_r;
    assign bus.s_syserr = syserr_r;
    assign bp_req = bp_req_r;
    assign bp_write = bp_wr_r;
    assign bp_kind = bpk_r;
    assign bp_addr = bpa_r;
    assign bp_am = bpam_r;
    assign bp_lanes = bpl_r;
    assign bp_wdata = bpw_r;
    assign reg_wr = rw_r;
    assign reg_wr_idx = rwi_r;
    assign selected = sel_r;
    assign spy_valid = spv_r;
    assign spy_data = spd_r;
endmodule

// [sim/cbf_bus_asserts.sv]
// Line-level checker for one master and one slave on the transfer bus.
// Assumes the resolved lines of cbf_bus_if and the bus clock and reset.
`timescale 1ns/1ps
module cbf_bus_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [3:0] cl,
    input wire logic as_l,
    input wire logic ds_l,
    input wire logic wt,
    input wire logic m_ad_oe,
    input wire logic s_ad_oe,
    input wire logic m_info_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] ct_r;
    // The code stands for one cycle only, so keep it for the data phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            ct_r <= 4'h0;
        else if ($rose(as_l))
            ct_r <= cl;
    end
    a_addr_first: assert property ($rose(as_l) |-> !ds_l ##1 !ds_l)
        else $error("data strobe in address phase");
    a_code_legal: assert property ($rose(as_l)
        |-> !(cl inside {4'h5, 4'h6, 4'h7, 4'hb})) else $error("bad code");
    a_info_held: assert property (as_l && $past(as_l) && $past(as_l, 2)
        |-> m_info_oe && $stable(cl))
        else $error("info lines dropped in cycle");
    a_one_driver: assert property (!(m_ad_oe && s_ad_oe))
        else $error("two drivers on ad");
    a_wait_answer: assert property ($rose(ds_l) && ct_r == 4'h8 |=> wt)
        else $error("no wait after data strobe");
    a_wait_release: assert property ($fell(ds_l) && wt |=> !wt)
        else $error("wait held after strobe fell");
    a_nc1_no_wait: assert property (ct_r == 4'h9 |-> !wt)
        else $error("wait in uncompelled cycle");
    a_ds_interlock: assert property ($rose(ds_l) && ct_r != 4'ha
        |-> !$past(wt)) else $error("strobe before wait fell");
    c_direct: cover property ($rose(as_l) && cl == 4'h8);
    c_slave_read: cover property (wt && s_ad_oe);
    c_pipelined: cover property ($rose(ds_l) && ct_r == 4'ha);
endmodule

// [sim/cable_bus_cycle_framing_tb.sv]
// Bench joining master and slave ends back to back over cbf_bus_if.
// Assumes cbf_pkg, the interface and both ends are compiled first.
`timescale 1ns/1ps
module cable_bus_cycle_framing_tb;
    typedef struct {logic [3:0] t; logic [4:0] d, rs; logic w, e;
        logic [31:0] v;} cbf_row_t;
    logic sys_clk = 0, arst_n = 0, req = 0, req_write = 0, ce = 1;
    logic bus_grant = 1, bcast_en = 1, bp_done = 0, bp_err = 0, tk, e;
    logic busy, wd_take, rd_valid, done, err, bp_req, bp_write;
    logic [1:0] req_dsel = 0, bp_kind;
    logic [3:0] req_type = 0;
    logic [4:0] req_dev = 0, req_rs = 0, req_beats = 0, own_dev = 5'h3;
    logic [5:0] req_ae = 0;
    logic [31:0] wdata = 0, req_addr = 32'h1234_5640, stat_in = 32'h5eed;
    logic [31:0] bp_rdata = 0, rd_data, bp_addr, bp_wdata, rq[$];
    logic [31:0] spy_data;
    logic [4:0] reg_wr_idx;
    int fails = 0, tests_run = 0;
    // Writes carry the data, reads the data expected back
    cbf_row_t rows[12] = '{'{4'h8, 5'h3, 5'h3, 1, 0, 32'ha5a5},
        '{4'h8, 5'h3, 5'h3, 0, 0, 32'ha5a5}, '{4'h9, 5'h3, 5'h4, 1, 0, 32'hbad},
        '{4'ha, 5'h3, 5'h4, 0, 0, 32'hbad}, '{4'h8, 5'h0, 5'h5, 1, 0, 32'hb0c},
        '{4'h8, 5'h3, 5'h5, 0, 0, 32'hb0c}, '{4'h8, 5'h3, 5'h0, 0, 0, 32'h5eed},
        '{4'h5, 5'h3, 5'h3, 1, 1, 32'h0}, '{4'hb, 5'h3, 5'h3, 1, 1, 32'h0},
        '{4'h7, 5'h3, 5'h3, 0, 1, 32'h0}, '{4'h9, 5'h3, 5'h3, 0, 1, 32'h0},
        '{4'ha, 5'h0, 5'h3, 0, 1, 32'h0}};
    cbf_bus_if cbf_bus_if_inst ();
    cbf_master cbf_master_inst (.sys_clk, .arst_n, .ce, .bus(cbf_bus_if_inst),
        .bus_grant, .req, .req_type, .req_dev, .req_addr, .req_ae, .req_rs,
        .req_write, .req_dsel, .req_beats, .wdata, .busy, .wd_take,
        .rd_valid, .rd_data, .done, .err);
    cbf_slave cbf_slave_inst (.sys_clk, .arst_n, .ce, .bus(cbf_bus_if_inst),
        .own_dev, .bcast_en, .stat_in, .bp_done, .bp_err, .bp_rdata, .bp_req,
        .bp_write, .bp_kind, .bp_addr, .bp_am(), .bp_lanes(), .bp_wdata,
        .reg_wr(), .reg_wr_idx, .selected(), .spy_valid(), .spy_data);
    cbf_bus_asserts cbf_bus_asserts_inst (.sys_clk, .arst_n,
        .cl(cbf_bus_if_inst.cl), .as_l(cbf_bus_if_inst.as_l),
        .ds_l(cbf_bus_if_inst.ds_l), .wt(cbf_bus_if_inst.wt),
        .m_ad_oe(cbf_bus_if_inst.m_ad_oe), .s_ad_oe(cbf_bus_if_inst.s_ad_oe),
        .m_info_oe(cbf_bus_if_inst.m_info_oe));
    initial forever #20 sys_clk = ~sys_clk;
    // Backplane answers one cycle after each request
    always @(posedge sys_clk) bp_done <= bp_req;
    task automatic chk(input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, x);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic op(input logic [3:0] t, input logic [4:0] d, rs, n,
                      input logic w, input logic [31:0] v);
        @(posedge sys_clk);
        {req, req_type, req_dev, req_rs, req_beats, req_write, wdata}
            <= {1'b1, t, d, rs, n, w, v};
        @(posedge sys_clk);
        req <= 0;
        rq = {};
        for (int i = 0; i < 99; i++) begin
            @(negedge sys_clk);
            tk = wd_take;
            e = err;
            if (rd_valid) rq.push_back(rd_data);
            if (done || err) break;
            if (i == 98) fails++;
            @(posedge sys_clk);
            if (tk) wdata <= wdata + 32'h1;
        end
    endtask
    initial begin
        #200000;
        fails++;
        complete_run;
    end
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1;
        @(negedge sys_clk);
        chk({busy, done, err, bp_req}, 0);
        foreach (rows[i]) begin
            op(rows[i].t, rows[i].d, rows[i].rs, 5'h1, rows[i].w, rows[i].v);
            chk(e, rows[i].e);
            if (!rows[i].w && !rows[i].e) chk(rq[0], rows[i].v);
            if (!rows[i].e) chk(spy_data, rows[i].v);
            if (rows[i].w && !rows[i].e) chk(reg_wr_idx, rows[i].rs);
            $display("row %0d done", i);
        end
        op(4'h8, 5'h3, 5'h1f, 5'h2, 1, 32'h1000);
        op(4'h8, 5'h3, 5'h1f, 5'h2, 0, 32'h0);
        chk(rq.size(), 2);
        chk(rq[0], 32'h1000);
        chk(rq[1], 32'h1001);
        $display("block test done");
        op(4'ha, 5'h3, 5'h1f, 5'h2, 0, 32'h0);
        chk(rq.size(), 2);
        chk(rq[0], 32'h1000);
        chk(rq[1], 32'h1001);
        $display("pipelined test done");
        op(4'hc, 5'h3, 5'h0, 5'h1, 1, 32'h77);
        chk(bp_kind, cbf_pkg::BPK_VME);
        chk(bp_addr, req_addr);
        chk(bp_wdata, 32'h77);
        op(4'h4, 5'h3, 5'h0, 5'h1, 1, 32'h55);
        chk(bp_kind, cbf_pkg::BPK_LANE);
        chk(bp_wdata, 32'h55);
        $display("backplane test done");
        @(posedge sys_clk) bus_grant <= 0;
        op(4'h8, 5'h3, 5'h3, 5'h1, 1, 32'h0);
        chk(e, 1);
        @(posedge sys_clk) bus_grant <= 1;
        $display("grant test done");
        @(posedge sys_clk) arst_n <= 0;
        @(posedge sys_clk) arst_n <= 1;
        op(4'h8, 5'h3, 5'h3, 5'h1, 0, 32'h0);
        chk(rq.size(), 1);
        chk(rq[0], cbf_pkg::REG_RST);
        $display("reset test done");
        complete_run;
    end
endmodule
